//--- rtl/adsc_axil_slave.sv
`timescale 1ns/1ps
`include "adsc_map.svh"

module adsc_axil_slave (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output adsc_pkg::adsc_reg_acc_s     acc,
  input  wire logic [7:0]             rd_data,
  input  wire logic                   rd_hit,
  input  wire logic                   wr_hit
);

  logic       aw_held, next_aw_held;
  logic [7:0] aw_idx, next_aw_idx;
  logic       w_held, next_w_held;
  logic [7:0] w_data, next_w_data;
  logic       w_lane0, next_w_lane0;
  logic       next_awready, next_wready, next_arready;
  logic       next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic       wr_fire, rd_fire;

  always_comb begin
    wr_fire      = aw_held && w_held && !s_axi_bvalid;
    rd_fire      = s_axi_arvalid && s_axi_arready;
    acc.wr       = wr_fire && w_lane0;
    acc.wr_idx   = aw_idx;
    acc.wdata    = w_data;
    acc.rd       = rd_fire;
    acc.rd_idx   = s_axi_araddr[9:2];
    next_aw_held = aw_held;
    next_aw_idx  = aw_idx;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? 2'h0 : 2'h2;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      // Narrow register in the low byte, upper bits read as zero
      next_rvalid = 1'b1;
      next_rdata  = {24'h00_0000, rd_hit ? rd_data : 8'h00};
      next_rresp  = rd_hit ? 2'h0 : 2'h2;
    end
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_idx        <= 8'h00;
      w_held        <= 1'b0;
      w_data        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      aw_held       <= next_aw_held;
      aw_idx        <= next_aw_idx;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_lane0       <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("Write response dropped before bready");

  property p_rvalid_after_ar;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rvalid_after_ar: assert property (p_rvalid_after_ar)
    else $error("Read answer missing one cycle after address");

endmodule : adsc_axil_slave

//--- rtl/adsc_top.sv
`timescale 1ns/1ps
`include "adsc_map.svh"

module adsc_top (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output adsc_pkg::adsc_conv_req_s    conv_req,
  input  wire adsc_pkg::adsc_conv_rsp_s conv_rsp
);

  adsc_pkg::adsc_reg_acc_s acc;
  logic [7:0]              rd_data;
  logic                    rd_hit;
  logic                    wr_hit;

  adsc_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .acc           (acc),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit),
    .wr_hit        (wr_hit)
  );

  // Control state
  logic [7:0]           scan_control, next_scan_control;
  adsc_pkg::adsc_mode_e mode, next_mode;
  logic                 continuous_conversion, next_continuous_conversion;
  logic                 start_pend, next_start_pend;
  // Result state
  logic [7:0]           primary_result_high, next_primary_result_high;
  logic [7:0]           primary_result_low, next_primary_result_low;
  logic [7:0]           scan_result [1:3];
  logic [7:0]           next_scan_result [1:3];
  logic                 low_locked, next_low_locked;
  // Sequencer state
  adsc_pkg::adsc_state_e    state, next_state;
  logic [1:0]               chan, next_chan;
  adsc_pkg::adsc_conv_req_s next_conv_req;

  logic [1:0] scan_count;
  logic       scan_enable;
  logic       scan_active;
  logic       trunc;

  always_comb begin
    scan_count  = scan_control[`ADSC_SCAN_CNT_MSB:`ADSC_SCAN_CNT_LSB];
    scan_enable = scan_control[`ADSC_SCAN_EN_BIT];
    trunc       = (mode == adsc_pkg::ADSC_TRUNC8);
    // Scanning only runs in truncated mode; otherwise plain channel 0
    scan_active = scan_enable && trunc;
  end

  // Register write and control
  always_comb begin
    wr_hit                     = 1'b1;
    next_scan_control          = scan_control;
    next_mode                  = mode;
    next_continuous_conversion = continuous_conversion;
    next_start_pend            = start_pend;
    if (state == adsc_pkg::ADSC_IDLE && start_pend) begin
      next_start_pend = 1'b0;
    end
    if (acc.wr) begin
      case (acc.wr_idx)
        `ADSC_IDX_SCAN_CTRL: begin
          // Upper bits are reserved and kept at zero
          next_scan_control = {5'h00, acc.wdata[2:0]};
        end
        `ADSC_IDX_CONV_CTRL: begin
          next_mode = adsc_pkg::adsc_mode_e'(
            acc.wdata[`ADSC_MODE_MSB:`ADSC_MODE_LSB]);
          next_continuous_conversion = acc.wdata[`ADSC_CONT_BIT];
          // A new start wins over the pending flag being consumed
          if (acc.wdata[`ADSC_CONV_START_BIT]) begin
            next_start_pend = 1'b1;
          end
        end
        `ADSC_IDX_PRIM_HIGH, `ADSC_IDX_PRIM_LOW, `ADSC_IDX_SCAN_CH1,
        `ADSC_IDX_SCAN_CH2, `ADSC_IDX_SCAN_CH3: begin
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end else if (!(acc.wr_idx inside {`ADSC_IDX_PRIM_HIGH, `ADSC_IDX_PRIM_LOW,
        `ADSC_IDX_SCAN_CH1, `ADSC_IDX_SCAN_CH2, `ADSC_IDX_SCAN_CH3,
        `ADSC_IDX_SCAN_CTRL, `ADSC_IDX_CONV_CTRL})) begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_control          <= `ADSC_SCAN_CTRL_RST;
      mode                  <= adsc_pkg::adsc_mode_e'(`ADSC_MODE_RST);
      continuous_conversion <= 1'b0;
      start_pend            <= 1'b0;
    end else begin
      scan_control          <= next_scan_control;
      mode                  <= next_mode;
      continuous_conversion <= next_continuous_conversion;
      start_pend            <= next_start_pend;
    end
  end

  // Register read
  always_comb begin
    rd_hit = 1'b1;
    case (acc.rd_idx)
      `ADSC_IDX_PRIM_HIGH: rd_data = primary_result_high;
      `ADSC_IDX_PRIM_LOW:  rd_data = primary_result_low;
      `ADSC_IDX_SCAN_CH1:  rd_data = scan_result[1];
      `ADSC_IDX_SCAN_CH2:  rd_data = scan_result[2];
      `ADSC_IDX_SCAN_CH3:  rd_data = scan_result[3];
      `ADSC_IDX_SCAN_CTRL: rd_data = scan_control;
      `ADSC_IDX_CONV_CTRL: rd_data = {3'h0, state == adsc_pkg::ADSC_BUSY,
                                      continuous_conversion, mode, 1'b0};
      default: begin
        rd_data = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Conversion sequencer
  always_comb begin
    next_state    = state;
    next_chan     = chan;
    next_conv_req = '{start: 1'b0, channel: conv_req.channel};
    case (state)
      adsc_pkg::ADSC_IDLE: begin
        if (start_pend) begin
          next_state    = adsc_pkg::ADSC_BUSY;
          next_chan     = 2'h0;
          next_conv_req = '{start: 1'b1, channel: 2'h0};
        end
      end
      adsc_pkg::ADSC_BUSY: begin
        if (conv_rsp.done) begin
          if (scan_active && chan < scan_count) begin
            next_chan     = chan + 2'h1;
            next_conv_req = '{start: 1'b1, channel: chan + 2'h1};
          end else if (continuous_conversion) begin
            next_chan     = 2'h0;
            next_conv_req = '{start: 1'b1, channel: 2'h0};
          end else begin
            next_state = adsc_pkg::ADSC_IDLE;
          end
        end
      end
      default: begin
        next_state = adsc_pkg::ADSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= adsc_pkg::ADSC_IDLE;
      chan     <= 2'h0;
      conv_req <= '{start: 1'b0, channel: 2'h0};
    end else begin
      state    <= next_state;
      chan     <= next_chan;
      conv_req <= next_conv_req;
    end
  end

  // Result storage
  logic store;
  always_comb begin
    store                    = (state == adsc_pkg::ADSC_BUSY) && conv_rsp.done;
    next_primary_result_high = primary_result_high;
    next_primary_result_low  = primary_result_low;
    next_low_locked          = low_locked;
    // Reading high freezes low in the justified modes until low is read
    if (acc.rd && acc.rd_idx == `ADSC_IDX_PRIM_HIGH && !trunc) begin
      next_low_locked = 1'b1;
    end
    if (acc.rd && acc.rd_idx == `ADSC_IDX_PRIM_LOW) begin
      next_low_locked = 1'b0;
    end
    if (store && chan == 2'h0 && (trunc || !low_locked)) begin
      case (mode)
        adsc_pkg::ADSC_TRUNC8: begin
          // No interlock here: every channel 0 completion overwrites
          next_primary_result_high = 8'h00;
          next_primary_result_low  = conv_rsp.result[9:2];
        end
        adsc_pkg::ADSC_RIGHT: begin
          next_primary_result_high = {6'h00, conv_rsp.result[9:8]};
          next_primary_result_low  = conv_rsp.result[7:0];
        end
        adsc_pkg::ADSC_LEFT: begin
          next_primary_result_high = conv_rsp.result[9:2];
          next_primary_result_low  = {conv_rsp.result[1:0], 6'h00};
        end
        default: begin
          next_primary_result_high = {~conv_rsp.result[9],
                                      conv_rsp.result[8:2]};
          next_primary_result_low  = {conv_rsp.result[1:0], 6'h00};
        end
      endcase
    end
  end

  for (genvar g = 1; g <= 3; g++) begin : g_scan_res
    always_comb begin
      next_scan_result[g] = scan_result[g];
      if (store && scan_active && chan == 2'(g)) begin
        next_scan_result[g] = conv_rsp.result[9:2];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        scan_result[g] <= `ADSC_RESULT_RST;
      end else begin
        scan_result[g] <= next_scan_result[g];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_result_high <= `ADSC_RESULT_RST;
      primary_result_low  <= `ADSC_RESULT_RST;
      low_locked          <= 1'b0;
    end else begin
      primary_result_high <= next_primary_result_high;
      primary_result_low  <= next_primary_result_low;
      low_locked          <= next_low_locked;
    end
  end

  // Checks
  logic [1:0] last_start_chan;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_start_chan <= 2'h0;
    end else if (conv_req.start) begin
      last_start_chan <= conv_req.channel;
    end
  end

  property p_scan_ch1_store;
    @(posedge aclk) disable iff (!aresetn)
    store && scan_active && chan == 2'h1
      |=> scan_result[1] == $past(conv_rsp.result[9:2]);
  endproperty
  a_scan_ch1_store: assert property (p_scan_ch1_store)
    else $error("Channel 1 scan result not stored");

  property p_scan_res_frozen;
    @(posedge aclk) disable iff (!aresetn)
    !trunc |=> $stable(scan_result[1]) && $stable(scan_result[2])
      && $stable(scan_result[3]);
  endproperty
  a_scan_res_frozen: assert property (p_scan_res_frozen)
    else $error("Scan result changed outside truncated mode");

  property p_chan_in_count;
    @(posedge aclk) disable iff (!aresetn)
    conv_req.start |-> conv_req.channel <= $past(scan_count);
  endproperty
  a_chan_in_count: assert property (p_chan_in_count)
    else $error("Converted channel beyond scan count");

  property p_reset_ctrl;
    @(posedge aclk)
    !aresetn |=> scan_control == 8'h00 && state == adsc_pkg::ADSC_IDLE;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("Scan control not cleared by reset");

  property p_no_scan_when_off;
    @(posedge aclk) disable iff (!aresetn)
    // The start pulse was decided one cycle earlier, so judge it by then
    !$past(scan_active) && conv_req.start |-> conv_req.channel == 2'h0;
  endproperty
  a_no_scan_when_off: assert property (p_no_scan_when_off)
    else $error("Channel beyond 0 converted with scan off");

  property p_trunc_low;
    @(posedge aclk) disable iff (!aresetn)
    store && trunc && chan == 2'h0
      |=> primary_result_low == $past(conv_rsp.result[9:2]);
  endproperty
  a_trunc_low: assert property (p_trunc_low)
    else $error("Truncated low result not refreshed");

  property p_ascending;
    @(posedge aclk) disable iff (!aresetn)
    conv_req.start && conv_req.channel != 2'h0
      |-> conv_req.channel == last_start_chan + 2'h1;
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("Scan channels not in ascending order");

  property p_locked_low;
    @(posedge aclk) disable iff (!aresetn)
    store && low_locked && !trunc |=> $stable(primary_result_low);
  endproperty
  a_locked_low: assert property (p_locked_low)
    else $error("Latched low result overwritten");

endmodule : adsc_top

//--- shared/adsc_map.svh
`ifndef ADSC_MAP_SVH
`define ADSC_MAP_SVH

`define ADSC_IDX_PRIM_HIGH   8'h59
`define ADSC_IDX_PRIM_LOW    8'h5a
`define ADSC_IDX_SCAN_CH1    8'h5b
`define ADSC_IDX_SCAN_CH2    8'h5c
`define ADSC_IDX_SCAN_CH3    8'h5d
`define ADSC_IDX_SCAN_CTRL   8'h5e
`define ADSC_IDX_CONV_CTRL   8'h5f

`define ADSC_SCAN_CNT_LSB    0
`define ADSC_SCAN_CNT_MSB    1
`define ADSC_SCAN_EN_BIT     2

`define ADSC_CONV_START_BIT  0
`define ADSC_MODE_LSB        1
`define ADSC_MODE_MSB        2
`define ADSC_CONT_BIT        3
`define ADSC_BUSY_BIT        4

`define ADSC_SCAN_CTRL_RST   8'h00
`define ADSC_MODE_RST        2'h1
`define ADSC_RESULT_RST      8'h00

`endif

//--- shared/adsc_pkg.sv
package adsc_pkg;

  typedef enum logic [1:0] {
    ADSC_TRUNC8,
    ADSC_RIGHT,
    ADSC_LEFT,
    ADSC_LEFT_SIGN
  } adsc_mode_e;

  typedef enum logic {
    ADSC_IDLE,
    ADSC_BUSY
  } adsc_state_e;

  // Request to the converter core
  typedef struct packed {
    logic       start;
    logic [1:0] channel;
  } adsc_conv_req_s;

  // Completion from the converter core
  typedef struct packed {
    logic       done;
    logic [9:0] result;
  } adsc_conv_rsp_s;

  // Register access strobes from the bus slave
  typedef struct packed {
    logic       wr;
    logic [7:0] wr_idx;
    logic [7:0] wdata;
    logic       rd;
    logic [7:0] rd_idx;
  } adsc_reg_acc_s;

endpackage : adsc_pkg

//--- test/adc_auto_scan_control_bench.sv
`timescale 1ns/1ps
`include "adsc_map.svh"

module adc_auto_scan_control_bench;
  logic                     aclk;
  logic                     aresetn;
  logic [11:0]              s_axi_awaddr;
  logic                     s_axi_awvalid;
  logic                     s_axi_awready;
  logic [31:0]              s_axi_wdata;
  logic [3:0]               s_axi_wstrb;
  logic                     s_axi_wvalid;
  logic                     s_axi_wready;
  logic [1:0]               s_axi_bresp;
  logic                     s_axi_bvalid;
  logic                     s_axi_bready;
  logic [11:0]              s_axi_araddr;
  logic                     s_axi_arvalid;
  logic                     s_axi_arready;
  logic [31:0]              s_axi_rdata;
  logic [1:0]               s_axi_rresp;
  logic                     s_axi_rvalid;
  logic                     s_axi_rready;
  adsc_pkg::adsc_conv_req_s conv_req;
  adsc_pkg::adsc_conv_rsp_s conv_rsp;
  logic [9:0]               res_tab [4];
  logic [7:0]               exp_r [4];
  logic [1:0]               ch_q [$];
  logic                     pend;
  logic [1:0]               cur;
  logic [1:0]               wait_cnt;
  logic                     slow;
  logic [31:0]              d;
  logic [1:0]               r;
  int                       num_errors;
  int                       n_compared;

  adsc_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .conv_req(conv_req), .conv_rsp(conv_rsp));

  always #2.5 aclk = ~aclk;

  // Converter core stand-in: alternates prompt and slow answers; result
  // shows garbage outside the done pulse so stale capture is caught
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend     <= 1'b0;
      wait_cnt <= 2'h0;
      slow     <= 1'b0;
      conv_rsp <= '0;
    end else begin
      conv_rsp.done   <= pend && (wait_cnt == 2'h0);
      conv_rsp.result <= (pend && (wait_cnt == 2'h0)) ? res_tab[cur]
                                                       : ~res_tab[cur];
      if (conv_req.start) begin
        pend     <= 1'b1;
        cur      <= conv_req.channel;
        wait_cnt <= slow ? 2'h3 : 2'h0;
        slow     <= ~slow;
        ch_q.push_back(conv_req.channel);
      end else if (pend) begin
        if (wait_cnt == 2'h0) pend <= 1'b0;
        else wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic ran_out;
    num_errors++;
    $display("BAD %0t handshake wait ran out", $time);
    summarize();
  endtask : ran_out

  task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_dat

  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp,
                         input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s resp %b exp %b", $time, what, got, exp);
    end
  endtask : chk_rsp

  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] dat,
                        input logic [3:0] strb, output logic [1:0] resp);
    int   n;
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, dat};
    s_axi_wstrb   <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1) break;
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (n == 200) ran_out();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] dat,
                        output logic [1:0] resp);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (n == 200) ran_out();
    dat  = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] dat;
    logic [1:0]  resp;
    axi_rd(idx, dat, resp);
    chk_rsp(resp, 2'b00, "read response");
    chk_dat(dat, {24'h00_0000, exp}, "register read");
  endtask : rd_chk

  task automatic chk_scan;
    for (int k = 1; k < 4; k++) rd_chk(`ADSC_IDX_PRIM_LOW + 8'(k), exp_r[k]);
  endtask : chk_scan

  task automatic run_scan(input logic [7:0] ctrl, input logic [1:0] mode,
                          input int nexp);
    int          n;
    logic [1:0]  resp;
    ch_q.delete();
    axi_wr(`ADSC_IDX_SCAN_CTRL, ctrl, 4'h1, resp);
    // Continuous bit stays clear whenever a scan is enabled
    axi_wr(`ADSC_IDX_CONV_CTRL, {5'h00, mode, 1'b1}, 4'h1, resp);
    for (n = 0; n < 500 && ch_q.size() < nexp; n++) @(posedge aclk);
    if (ch_q.size() < nexp) ran_out();
    repeat (40) @(posedge aclk);
    chk_dat(32'(ch_q.size()), 32'(nexp), "conversions");
    for (n = 0; n < ch_q.size(); n++)
      chk_dat({30'h0, ch_q[n]}, 32'(n), "channel order");
  endtask : run_scan

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    num_errors = 0;
    n_compared = 0;
    for (int k = 0; k < 4; k++) res_tab[k] = 10'h000;
    for (int k = 0; k < 4; k++) exp_r[k] = 8'h00;
    do_reset();
    chk_scan();
    rd_chk(`ADSC_IDX_SCAN_CTRL, 8'h00);
    rd_chk(`ADSC_IDX_CONV_CTRL, 8'h02);
    axi_wr(`ADSC_IDX_SCAN_CH1, 8'hff, 4'h1, r);
    chk_rsp(r, 2'b00, "read-only write");
    rd_chk(`ADSC_IDX_SCAN_CH1, 8'h00);
    axi_wr(`ADSC_IDX_SCAN_CTRL, 8'h07, 4'h0, r);
    rd_chk(`ADSC_IDX_SCAN_CTRL, 8'h00);
    axi_rd(8'h20, d, r);
    chk_rsp(r, 2'b10, "unmapped read");
    chk_dat(d, 32'h0000_0000, "unmapped data");
    $display("test reset_and_access done");
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) res_tab[k] = 10'(709 + c * 59 + k * 151);
      run_scan(8'h04 | 8'(c), 2'b00, c + 1);
      for (int k = 1; k <= c; k++) exp_r[k] = res_tab[k][9:2];
      rd_chk(`ADSC_IDX_PRIM_LOW, res_tab[0][9:2]);
      rd_chk(`ADSC_IDX_PRIM_HIGH, 8'h00);
      chk_scan();
      rd_chk(`ADSC_IDX_SCAN_CTRL, 8'h04 | 8'(c));
      rd_chk(`ADSC_IDX_CONV_CTRL, 8'h00);
    end
    $display("test scan_counts done");
    for (int k = 0; k < 4; k++) res_tab[k] = 10'h155 + 10'(k);
    run_scan(8'h03, 2'b00, 1);
    rd_chk(`ADSC_IDX_PRIM_LOW, res_tab[0][9:2]);
    chk_scan();
    $display("test scan_disabled done");
    for (int k = 0; k < 4; k++) res_tab[k] = 10'h2aa - 10'(k);
    run_scan(8'h07, 2'b01, 1);
    chk_scan();
    // Reading high in a justified mode must hold low against new results
    rd_chk(`ADSC_IDX_PRIM_HIGH, {6'h00, res_tab[0][9:8]});
    for (int k = 0; k < 4; k++) res_tab[k] = 10'h0f0;
    run_scan(8'h07, 2'b01, 1);
    rd_chk(`ADSC_IDX_PRIM_LOW, 8'haa);
    rd_chk(`ADSC_IDX_PRIM_HIGH, 8'h02);
    $display("test not_truncated done");
    axi_wr(`ADSC_IDX_SCAN_CTRL, 8'h07, 4'h1, r);
    do_reset();
    for (int k = 0; k < 4; k++) exp_r[k] = 8'h00;
    rd_chk(`ADSC_IDX_SCAN_CTRL, 8'h00);
    chk_scan();
    $display("test second_reset done");
    summarize();
  end
endmodule : adc_auto_scan_control_bench
